// *** sscl_pkg.sv ***
// Package with constants and types for the start/stop command logic
// ==========================================================================
package sscl_pkg;

  // ========================================================================
  // Stop selection encodings
  localparam logic [13:0] STOP_SEL_RESET   = 14'h270f;
  localparam logic [13:0] STOP_SEL_DECEL_A = 14'h270f;
  localparam logic [13:0] STOP_SEL_DECEL_B = 14'h22b8;
  localparam logic [13:0] STOP_SEL_LO_MAX  = 14'h0064;
  localparam logic [13:0] STOP_SEL_HI_MIN  = 14'h03e8;
  localparam logic [13:0] STOP_SEL_HI_MAX  = 14'h044c;

  // ========================================================================
  // Terminal function codes
  localparam logic [7:0] FUNC_STOP      = 8'h19;
  localparam logic [7:0] FUNC_FWD_START = 8'h3c;
  localparam logic [7:0] FUNC_REV_START = 8'h3d;
  localparam int         TERM_COUNT     = 8;
  localparam logic [7:0] TERM_RESET     = 8'hff;

  // ========================================================================
  // Timing
  localparam int CLK_HZ          = 200000000;
  localparam int SEC_TICK_CYCLES = CLK_HZ;

  typedef enum logic [1:0] {
    SSCL_IDLE  = 2'b00,
    SSCL_RUN   = 2'b01,
    SSCL_DECEL = 2'b11,
    SSCL_COAST = 2'b10
  } sscl_state_e;

  typedef struct packed {
    logic run;
    logic reverse;
    logic decel;
    logic coast;
  } sscl_cmd_s;

endpackage : sscl_pkg

// *** sscl_sync.sv ***
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module sscl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sscl_sync

// *** sscl_tick.sv ***
// Divider giving a one-cycle enable once per second
`timescale 1ns/1ps
module sscl_tick #(
  parameter int CYCLES = sscl_pkg::SEC_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clr,
  output logic      tick
);
  logic [31:0] cnt_q;

  initial begin
    if (CYCLES < 2) $error("CYCLES must be at least 2");
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (clr) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule : sscl_tick

// *** sscl_top.sv ***
// Start/stop command decoding with three-wire latch and stop method
`timescale 1ns/1ps
module sscl_top #(
  parameter int SEC_CYCLES = sscl_pkg::SEC_TICK_CYCLES,
  parameter int NTERM      = sscl_pkg::TERM_COUNT
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RST_B,
  input  wire logic [NTERM-1:0]    TERM_IN,
  input  wire logic                JOG_IN,
  input  wire logic                OUTPUT_SHUTOFF_INPUT,
  input  wire logic                STOP_SEL_WR,
  input  wire logic [13:0]         STOP_SEL_WDATA,
  input  wire logic                TERM_FUNC_WR,
  input  wire logic [7:0]          TERM_FUNC_IDX,
  input  wire logic [7:0]          TERM_FUNC_WDATA,
  output logic [13:0]              STOP_SEL_PARAM,
  output logic                     STOP_SEL_REJECT,
  output logic                     TERM_FUNC_REJECT,
  output logic                     RUN_CMD,
  output logic                     REVERSE_CMD,
  output logic                     DECEL_CMD,
  output logic                     COAST_CMD,
  output logic                     OUTPUT_ENABLE,
  output logic                     START_LATCHED
);

  // ========================================================================
  // Parameter checks
  initial begin
    if (NTERM < 3 || NTERM > 255) $error("NTERM must be 3..255");
  end

  // ========================================================================
  // Input synchronisation
  logic [NTERM-1:0] term_s;
  logic             jog_s;
  logic             shut_s;

  sscl_sync #(.W(NTERM + 2)) u_sync (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .d     ({JOG_IN, OUTPUT_SHUTOFF_INPUT, TERM_IN}),
    .q     ({jog_s, shut_s, term_s})
  );

  // ========================================================================
  // Terminal function assignment
  logic [7:0] func_q [NTERM];
  logic       func_ok;

  always_comb begin
    func_ok = 1'b1;
    if (TERM_FUNC_IDX >= 8'(NTERM)) func_ok = 1'b0;
    if (TERM_FUNC_WDATA == sscl_pkg::FUNC_FWD_START && TERM_FUNC_IDX != 8'h00) func_ok = 1'b0;
    if (TERM_FUNC_WDATA == sscl_pkg::FUNC_REV_START && TERM_FUNC_IDX != 8'h01) func_ok = 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NTERM; gi++) begin : g_func
      always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          if (gi == 0) func_q[gi] <= sscl_pkg::FUNC_FWD_START;
          else if (gi == 1) func_q[gi] <= sscl_pkg::FUNC_REV_START;
          else if (gi == 2) func_q[gi] <= sscl_pkg::FUNC_STOP;
          else func_q[gi] <= sscl_pkg::TERM_RESET;
        end else if (TERM_FUNC_WR && func_ok && TERM_FUNC_IDX == 8'(gi)) begin
          func_q[gi] <= TERM_FUNC_WDATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TERM_FUNC_REJECT <= 1'b0;
    end else begin
      TERM_FUNC_REJECT <= TERM_FUNC_WR && !func_ok;
    end
  end

  // Signals picked from terminals by function code
  logic fwd_in;
  logic rev_in;
  logic stop_in;

  always_comb begin
    fwd_in  = (func_q[0] == sscl_pkg::FUNC_FWD_START) && term_s[0];
    rev_in  = (func_q[1] == sscl_pkg::FUNC_REV_START) && term_s[1];
    stop_in = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (func_q[i] == sscl_pkg::FUNC_STOP && term_s[i]) stop_in = 1'b1;
    end
  end

  // ========================================================================
  // Stop selection setting
  logic sel_ok;

  always_comb begin
    sel_ok = (STOP_SEL_WDATA <= sscl_pkg::STOP_SEL_LO_MAX)
          || (STOP_SEL_WDATA >= sscl_pkg::STOP_SEL_HI_MIN && STOP_SEL_WDATA <= sscl_pkg::STOP_SEL_HI_MAX)
          || (STOP_SEL_WDATA == sscl_pkg::STOP_SEL_DECEL_A)
          || (STOP_SEL_WDATA == sscl_pkg::STOP_SEL_DECEL_B);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      STOP_SEL_PARAM  <= sscl_pkg::STOP_SEL_RESET;
      STOP_SEL_REJECT <= 1'b0;
    end else begin
      STOP_SEL_REJECT <= STOP_SEL_WR && !sel_ok;
      if (STOP_SEL_WR && sel_ok) STOP_SEL_PARAM <= STOP_SEL_WDATA;
    end
  end

  logic        mode_dir;
  logic        decel_stop;
  logic [13:0] coast_secs;

  always_comb begin
    mode_dir   = (STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_B)
              || (STOP_SEL_PARAM >= sscl_pkg::STOP_SEL_HI_MIN && STOP_SEL_PARAM <= sscl_pkg::STOP_SEL_HI_MAX);
    decel_stop = (STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_A)
              || (STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_B);
    if (STOP_SEL_PARAM >= sscl_pkg::STOP_SEL_HI_MIN && STOP_SEL_PARAM <= sscl_pkg::STOP_SEL_HI_MAX) begin
      coast_secs = STOP_SEL_PARAM - sscl_pkg::STOP_SEL_HI_MIN;
    end else begin
      coast_secs = STOP_SEL_PARAM;
    end
  end

  // ========================================================================
  // Start decoding and three-wire latch
  logic req_run;
  logic req_rev;

  always_comb begin
    if (mode_dir) begin
      req_run = fwd_in;
      req_rev = rev_in;
    end else begin
      req_run = fwd_in ^ rev_in;
      req_rev = rev_in && !fwd_in;
    end
  end

  logic three_wire;
  logic fwd_d1_q;
  logic rev_d1_q;
  logic latch_q;
  logic latch_rev_q;
  logic fwd_fall;
  logic rev_fall;

  assign three_wire = stop_in || jog_s;
  assign fwd_fall   = fwd_d1_q && !fwd_in;
  assign rev_fall   = rev_d1_q && !rev_in;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fwd_d1_q <= 1'b0;
      rev_d1_q <= 1'b0;
    end else begin
      fwd_d1_q <= fwd_in;
      rev_d1_q <= rev_in;
    end
  end

  // Latch is untouched by output shutoff
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      latch_q     <= 1'b0;
      latch_rev_q <= 1'b0;
    end else if (jog_s) begin
      latch_q <= latch_q;
    end else if (!stop_in) begin
      latch_q <= 1'b0;
    end else if (mode_dir && fwd_fall) begin
      latch_q     <= 1'b1;
      latch_rev_q <= rev_in;
    end else if (!mode_dir && (fwd_fall || rev_fall)) begin
      latch_q     <= 1'b1;
      latch_rev_q <= rev_fall;
    end
  end

  logic eff_run;
  logic eff_rev;

  always_comb begin
    if (jog_s) begin
      eff_run = req_run;
      eff_rev = req_rev;
    end else if (three_wire) begin
      eff_run = latch_q || req_run || fwd_fall || (!mode_dir && rev_fall);
      if (req_run) eff_rev = req_rev;
      else if (mode_dir) eff_rev = rev_in;
      else if (fwd_fall || rev_fall) eff_rev = rev_fall;
      else eff_rev = latch_rev_q;
    end else begin
      eff_run = req_run;
      eff_rev = req_rev;
    end
  end

  // ========================================================================
  // Run state and stop method
  sscl_pkg::sscl_state_e state_q;
  logic [13:0]           secs_q;
  logic                  sec_tick;

  sscl_tick #(.CYCLES(SEC_CYCLES)) u_tick (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .clr   (state_q != sscl_pkg::SSCL_DECEL),
    .tick  (sec_tick)
  );

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= sscl_pkg::SSCL_IDLE;
      secs_q  <= '0;
    end else if (shut_s) begin
      state_q <= sscl_pkg::SSCL_COAST;
      secs_q  <= '0;
    end else begin
      case (state_q)
        sscl_pkg::SSCL_IDLE, sscl_pkg::SSCL_COAST: begin
          if (eff_run) state_q <= sscl_pkg::SSCL_RUN;
          else state_q <= sscl_pkg::SSCL_IDLE;
        end
        sscl_pkg::SSCL_RUN: begin
          secs_q <= '0;
          if (!eff_run) begin
            if (!decel_stop && coast_secs == 14'h0000) state_q <= sscl_pkg::SSCL_COAST;
            else state_q <= sscl_pkg::SSCL_DECEL;
          end
        end
        sscl_pkg::SSCL_DECEL: begin
          if (eff_run) begin
            state_q <= sscl_pkg::SSCL_RUN;
          end else if (!decel_stop && sec_tick) begin
            secs_q <= secs_q + 14'h0001;
            if (secs_q + 14'h0001 >= coast_secs) state_q <= sscl_pkg::SSCL_COAST;
          end
        end
        default: state_q <= sscl_pkg::SSCL_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RUN_CMD       <= 1'b0;
      REVERSE_CMD   <= 1'b0;
      DECEL_CMD     <= 1'b0;
      COAST_CMD     <= 1'b0;
      OUTPUT_ENABLE <= 1'b0;
      START_LATCHED <= 1'b0;
    end else begin
      RUN_CMD       <= eff_run && !shut_s;
      if (eff_run) REVERSE_CMD <= eff_rev;
      DECEL_CMD     <= (state_q == sscl_pkg::SSCL_DECEL) && !eff_run && !shut_s;
      COAST_CMD     <= shut_s || (state_q == sscl_pkg::SSCL_COAST && !eff_run);
      OUTPUT_ENABLE <= !shut_s && (state_q == sscl_pkg::SSCL_RUN || state_q == sscl_pkg::SSCL_DECEL);
      START_LATCHED <= latch_q;
    end
  end

endmodule : sscl_top

// *** sscl_props.sv ***
// Checker for the start/stop command logic ports
`timescale 1ns/1ps
module sscl_props #(
  parameter int SEC_CYCLES = 10,
  parameter int NTERM      = 8
) (
  input wire logic             CORE_CLK,
  input wire logic             RST_B,
  input wire logic [NTERM-1:0] TERM_IN,
  input wire logic             JOG_IN,
  input wire logic             OUTPUT_SHUTOFF_INPUT,
  input wire logic             STOP_SEL_WR,
  input wire logic [13:0]      STOP_SEL_WDATA,
  input wire logic [13:0]      STOP_SEL_PARAM,
  input wire logic             STOP_SEL_REJECT,
  input wire logic             RUN_CMD,
  input wire logic             REVERSE_CMD,
  input wire logic             DECEL_CMD,
  input wire logic             COAST_CMD,
  input wire logic             OUTPUT_ENABLE,
  input wire logic             START_LATCHED
);
  // ==========================================================================
  // Helpers
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  function automatic logic ok(input logic [13:0] v);
    return v <= sscl_pkg::STOP_SEL_LO_MAX || v == sscl_pkg::STOP_SEL_DECEL_A || v == sscl_pkg::STOP_SEL_DECEL_B
      || (v >= sscl_pkg::STOP_SEL_HI_MIN && v <= sscl_pkg::STOP_SEL_HI_MAX);
  endfunction : ok
  logic two_w;
  assign two_w = !JOG_IN && !OUTPUT_SHUTOFF_INPUT && !TERM_IN[2];
  sequence s_shut;
    OUTPUT_SHUTOFF_INPUT [*6];
  endsequence
  sequence s_hold_latch;
    (OUTPUT_SHUTOFF_INPUT && TERM_IN[2] && !JOG_IN) [*6] ##0 START_LATCHED;
  endsequence
  // ==========================================================================
  // Assertions
  chk_bad_refused: assert property (STOP_SEL_WR && !ok(STOP_SEL_WDATA) |=>
    STOP_SEL_REJECT && STOP_SEL_PARAM == $past(STOP_SEL_PARAM)) else $error("bad setting taken");
  chk_good_taken: assert property (STOP_SEL_WR && ok(STOP_SEL_WDATA) |=>
    !STOP_SEL_REJECT && STOP_SEL_PARAM == $past(STOP_SEL_WDATA)) else $error("good setting lost");
  chk_shutoff_cut: assert property (s_shut |-> !OUTPUT_ENABLE && !RUN_CMD)
    else $error("output on in shutoff");
  chk_latch_kept: assert property (s_hold_latch |=> START_LATCHED)
    else $error("latch lost in shutoff");
  chk_run_excl: assert property (RUN_CMD |-> !DECEL_CMD && !COAST_CMD)
    else $error("run with stop command");
  chk_decel_no_coast: assert property ((!OUTPUT_SHUTOFF_INPUT && DECEL_CMD
    && (STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_A || STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_B)) [*6]
    |-> !COAST_CMD) else $error("coast in decel mode");
  chk_both_stop: assert property ((two_w && STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_A
    && TERM_IN[1:0] == 2'h3) [*6] |-> !RUN_CMD) else $error("run with both starts");
  chk_dir_select: assert property ((two_w && STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_B
    && TERM_IN[1:0] == 2'h3) [*6] |-> RUN_CMD && REVERSE_CMD) else $error("direction select wrong");
  chk_fwd_only: assert property ((two_w && STOP_SEL_PARAM == sscl_pkg::STOP_SEL_DECEL_A
    && TERM_IN[1:0] == 2'h1) [*6] |-> RUN_CMD && !REVERSE_CMD) else $error("forward run wrong");
endmodule : sscl_props

// *** sscl_switch_model.sv ***
// Switch model driving the input terminals
`timescale 1ns/1ps
module sscl_switch_model (
  input  wire logic       clk,
  input  wire logic [3:0] lv,
  output logic      [7:0] term
);
  // ==========================================================================
  // Contacts move on the clock edge, spare terminals stay open
  always_ff @(posedge clk) begin
    term <= {4'h0, lv};
  end
endmodule : sscl_switch_model

// *** sscl_top_test.sv ***
// Self-checking bench for the start/stop command logic
`timescale 1ns/1ps
module sscl_top_test;
  localparam int SEC = 10;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  lv = 4'h0;
  logic [7:0]  term;
  logic        jog = 1'b0, shut = 1'b0, sel_wr = 1'b0, fn_wr = 1'b0;
  logic [13:0] sel_d = 14'h0000, param;
  logic [7:0]  fn_idx = 8'h00, fn_d = 8'h00;
  logic        sel_rej, fn_rej, run, rev, dec, cst, oe, lat;
  int          n_mismatch = 0, num_checks = 0, cycles = 0, n;
  logic [13:0] bad [6] = '{14'h0065, 14'h03e7, 14'h044d, 14'h22b7, 14'h2710, 14'h3fff};
  logic [13:0] good [6] = '{14'h0000, 14'h0064, 14'h03e8, 14'h044c, 14'h22b8, 14'h270f};
  logic [7:0]  fidx [8] = '{8'h03, 8'h01, 8'h00, 8'h00, 8'h01, 8'h08, 8'h02, 8'h03};
  logic [7:0]  fcod [8] = '{8'h3c, 8'h3c, 8'h3c, 8'h3d, 8'h3d, 8'h19, 8'hff, 8'h19};
  logic        frej [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  always #2.5 clk = ~clk;
  sscl_switch_model u_sscl_switch_model (.clk(clk), .lv(lv), .term(term));
  sscl_top #(.SEC_CYCLES(SEC)) u_sscl_top (.CORE_CLK(clk), .RST_B(rst_b), .TERM_IN(term), .JOG_IN(jog),
    .OUTPUT_SHUTOFF_INPUT(shut), .STOP_SEL_WR(sel_wr), .STOP_SEL_WDATA(sel_d), .TERM_FUNC_WR(fn_wr),
    .TERM_FUNC_IDX(fn_idx), .TERM_FUNC_WDATA(fn_d), .STOP_SEL_PARAM(param), .STOP_SEL_REJECT(sel_rej),
    .TERM_FUNC_REJECT(fn_rej), .RUN_CMD(run), .REVERSE_CMD(rev), .DECEL_CMD(dec), .COAST_CMD(cst),
    .OUTPUT_ENABLE(oe), .START_LATCHED(lat));
  // ==========================================================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic pins(input logic [3:0] v);
    lv = v;
    step(8);
  endtask : pins
  task automatic wr_sel(input logic [13:0] v, input logic r);
    sel_wr = 1'b1;
    sel_d = v;
    step(1);
    sel_wr = 1'b0;
    chk("sel_rej", 14'(r), 14'(sel_rej));
    step(1);
  endtask : wr_sel
  // ==========================================================================
  // Sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    step(3);
    rst_b = 1'b1;
    step(1);
    chk("param", 14'h270f, param);
    foreach (bad[i]) begin
      wr_sel(bad[i], 1'b1);
      chk("param", 14'h270f, param);
    end
    foreach (good[i]) begin
      wr_sel(good[i], 1'b0);
      chk("param", good[i], param);
    end
    pins(4'h1);
    chk("cmd", 14'h0009, 14'({run, rev, dec, oe}));
    pins(4'h2);
    chk("cmd", 14'h0006, 14'({run, rev, dec}));
    pins(4'h3);
    chk("cmd", 14'h0002, 14'({run, dec, cst}));
    wr_sel(14'h22b8, 1'b0);
    pins(4'h1);
    chk("cmd", 14'h0004, 14'({run, rev, dec}));
    pins(4'h3);
    chk("cmd", 14'h0006, 14'({run, rev, dec}));
    pins(4'h2);
    chk("cmd", 14'h0002, 14'({run, dec, cst}));
    for (int i = 0; i < 2; i++) begin
      wr_sel(i ? 14'h03ea : 14'h0002, 1'b0);
      pins(4'h1);
      lv = 4'h0;
      n = 0;
      while (cst !== 1'b1 && n < 100) begin
        step(1);
        n++;
      end
      chk("coast_delay", 14'h0001, 14'(n >= 2 * SEC && n <= 2 * SEC + 8));
      step(4);
    end
    wr_sel(14'h270f, 1'b0);
    pins(4'h1);
    pins(4'h0);
    step(40);
    chk("cmd", 14'h0002, 14'({run, dec, cst}));
    pins(4'h4);
    pins(4'h5);
    pins(4'h4);
    chk("latch", 14'h0009, 14'({run, rev, dec, lat}));
    pins(4'h6);
    pins(4'h4);
    chk("latch", 14'h0007, 14'({run, rev, lat}));
    shut = 1'b1;
    step(8);
    chk("shutoff", 14'h0001, 14'({oe, run, lat}));
    shut = 1'b0;
    step(8);
    chk("resume", 14'h0003, 14'({run, lat}));
    pins(4'h0);
    chk("stop", 14'h0002, 14'({run, dec, lat}));
    jog = 1'b1;
    pins(4'h5);
    chk("jog", 14'h0001, 14'(run));
    pins(4'h4);
    chk("jog", 14'h0000, 14'({run, lat}));
    pins(4'h0);
    jog = 1'b0;
    step(8);
    foreach (fidx[i]) begin
      fn_wr = 1'b1;
      fn_idx = fidx[i];
      fn_d = fcod[i];
      step(1);
      fn_wr = 1'b0;
      chk("fn_rej", 14'(frej[i]), 14'(fn_rej));
      step(1);
    end
    pins(4'h8);
    pins(4'h9);
    pins(4'h8);
    chk("moved_stop", 14'h0001, 14'(lat));
    pins(4'h0);
    chk("moved_stop", 14'h0000, 14'(lat));
    results();
  end
endmodule : sscl_top_test
bind sscl_top sscl_props #(.SEC_CYCLES(SEC_CYCLES), .NTERM(NTERM)) u_sscl_props (.CORE_CLK(CORE_CLK),
  .RST_B(RST_B), .TERM_IN(TERM_IN), .JOG_IN(JOG_IN), .OUTPUT_SHUTOFF_INPUT(OUTPUT_SHUTOFF_INPUT),
  .STOP_SEL_WR(STOP_SEL_WR), .STOP_SEL_WDATA(STOP_SEL_WDATA), .STOP_SEL_PARAM(STOP_SEL_PARAM),
  .STOP_SEL_REJECT(STOP_SEL_REJECT), .RUN_CMD(RUN_CMD), .REVERSE_CMD(REVERSE_CMD), .DECEL_CMD(DECEL_CMD),
  .COAST_CMD(COAST_CMD), .OUTPUT_ENABLE(OUTPUT_ENABLE), .START_LATCHED(START_LATCHED));
